// ==== design/synth_defines.svh ====
// Bit positions, reset values and counts for the synthesizer control logic.
// Assumes a 24-bit serial word with the latch select in the two lowest bits.
`ifndef SYNTH_DEFINES_SVH
`define SYNTH_DEFINES_SVH
// ==========================================================
// Word layout common to all latches
`define WORD_BITS 24
`define SEL_MSB 1
`define SEL_LSB 0
`define LATCH_RESET 24'h00_0000
// ==========================================================
// Mode control word
`define CW_PRESC_MSB 23
`define CW_PRESC_LSB 22
`define CW_PD_SYNC 21
`define CW_PD_ARM 20
`define CW_CUR_HI_MSB 19
`define CW_CUR_HI_LSB 17
`define CW_CUR_LO_MSB 16
`define CW_CUR_LO_LSB 14
`define CW_PWR_MSB 13
`define CW_PWR_LSB 12
`define CW_MUTE 11
`define CW_GAIN 10
`define CW_TRISTATE 9
`define CW_POLARITY 8
`define CW_MUX_MSB 7
`define CW_MUX_LSB 5
`define CW_CLEAR 4
`define CW_CORE_MSB 3
`define CW_CORE_LSB 2
// ==========================================================
// Feedback divider word
`define FW_SRC_SEL 23
`define FW_HALVE 22
`define FW_GAIN 21
`define FW_MAIN_MSB 20
`define FW_MAIN_LSB 8
`define FW_SWAL_MSB 6
`define FW_SWAL_LSB 2
// ==========================================================
// Reference divider word
`define RW_BAND_MSB 21
`define RW_BAND_LSB 20
`define RW_TEST 19
`define RW_PRECISION 18
`define RW_ABP_MSB 17
`define RW_ABP_LSB 16
`define RW_DIV_MSB 15
`define RW_DIV_LSB 2
// ==========================================================
// Counts
`define LOCK_CNT_FAST 3
`define LOCK_CNT_PRECISE 5
`endif

// ==== design/synth_pkg.sv ====
// Types shared by the synthesizer control modules.
// Assumes synth_defines.svh supplies the field positions.
package synth_pkg;
  // Latch addressed by the two select bits
  typedef enum logic [1:0] {
    SEL_CONTROL = 2'b00,
    SEL_REFDIV = 2'b01,
    SEL_FEEDBACK = 2'b10,
    SEL_TEST = 2'b11
  } latch_sel_t;
  // Power state sequence
  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_WAIT0 = 2'b01,
    PD_WAIT1 = 2'b10,
    PD_DOWN = 2'b11
  } pd_state_t;
endpackage : synth_pkg

// ==== design/serial_word_if.sv ====
// Carries a completed serial word and its transfer pulse.
// Assumes both ends run on mclk.
`timescale 1ns/1ns
interface serial_word_if;
  logic [23:0] word;
  logic load;
  modport src (output word, output load);
  modport dst (input word, input load);
endinterface : serial_word_if

// ==== design/serial_shifter.sv ====
// Three-wire serial input register: shift on serial clock rise, transfer on strobe rise.
// Assumes pins are synchronous to mclk and the serial clock is no faster than mclk/2.
`timescale 1ns/1ns
`include "synth_defines.svh"
module serial_shifter (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  // Completed word
  serial_word_if.src out
);
  logic [`WORD_BITS-1:0] shift;
  logic clk_prev;
  logic strobe_prev;

  // Edge history; never gated by power-down so words keep arriving
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      clk_prev <= 1'b0;
      strobe_prev <= 1'b0;
    end
    else
    begin
      clk_prev <= ser_clk;
      strobe_prev <= load_strobe;
    end
  end

  // MSB first: new bits enter at the bottom
  always_ff @(posedge mclk)
  begin
    if (reset)
      shift <= `LATCH_RESET;
    else if (ser_clk && !clk_prev)
      shift <= {shift[`WORD_BITS-2:0], ser_data}; // [R23]
  end

  // Transfer on strobe rise, one-cycle pulse with registered word
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      out.word <= `LATCH_RESET;
      out.load <= 1'b0;
    end
    else
    begin
      out.load <= load_strobe && !strobe_prev; // [R23]
      if (load_strobe && !strobe_prev)
        out.word <= shift;
    end
  end
endmodule : serial_shifter

// ==== design/lock_detector.sv ====
// Digital lock detector evaluated once per reference divider cycle.
// Assumes the phase error comparisons arrive as levels valid at each tick.
`timescale 1ns/1ns
module lock_detector #(
  parameter int FAST_COUNT = 3,
  parameter int PRECISE_COUNT = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic precise,
  // Phase error per cycle
  input wire logic err_small,
  input wire logic err_large,
  // Result
  output logic locked
);
  logic [2:0] good;
  logic [2:0] need;

  if (FAST_COUNT < 1 || PRECISE_COUNT > 7 || FAST_COUNT > PRECISE_COUNT)
  begin : bad_counts
    $error("lock_detector: counts must satisfy 1 <= fast <= precise <= 7");
  end

  assign need = precise ? 3'(PRECISE_COUNT) : 3'(FAST_COUNT);

  // Enter after a run of good cycles, leave on one cycle with a large error
  always_ff @(posedge mclk)
  begin
    if (reset || clear)
    begin
      good <= 3'h0;
      locked <= 1'b0; // [R5]
    end
    else if (tick)
    begin
      if (locked)
      begin
        if (err_large)
        begin
          locked <= 1'b0; // [R25]
          good <= 3'h0;
        end
      end
      else if (err_small)
      begin
        good <= good + 3'h1;
        if (good + 3'h1 >= need)
          locked <= 1'b1; // [R19]
      end
      else
        good <= 3'h0;
    end
  end
endmodule : lock_detector

// ==== design/synth_serial_latch_control.sv ====
// Digital control section of an integer-N synthesizer: latches, power-down, dividers.
// Assumes all pins synchronous to mclk; analog sections consume the outputs.
//
// How it works
// R1 - Low two bits pick the target latch
// R2 - Armed, async selected: power down immediately
// R3 - Armed, sync: down on second reference tick
// R4 - Chip enable low disables at once
// R5 - Power-down loads counters, kills pump, lock, RF
// R6 - Serial register keeps loading during power-down
// R7 - Gain flag picks high or low current field
// R8 - Two word bits share one gain flag
// R9 - Mute keeps RF off until lock
// R10 - Tri-state bit floats the charge pump
// R11 - Polarity bit selects phase detector sense
// R12 - Count clear holds all dividers reset
// R13 - Five-bit swallow count, 0 to 31
// R14 - Thirteen-bit main count, 3 to 8191
// R15 - Host writes spare bits as zero
// R16 - Halving bit and prescaler source select
// R17 - Fourteen-bit reference ratio, 1 to 16383
// R18 - Two-bit antibacklash width field
// R19 - Lock after three or five good cycles
// R20 - Test latch ignored while test bit clear
// R21 - Band clock divider after reference divider
// R22 - Host writes reference, control, feedback order
// R23 - MSB-first shifting, transfer on strobe rise
// R24 - Band divider ratio 1, 2, 4, 8
// R25 - Lock holds until one large error
// R26 - Latch holds until its own word arrives
`timescale 1ns/1ns
`include "synth_defines.svh"
module synth_serial_latch_control #(
  parameter int WORD_W = 24
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Serial pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  // Chip pins and loop inputs
  input wire logic chip_enable_pin,
  input wire logic ref_in,
  input wire logic phase_err_small,
  input wire logic phase_err_large,
  // Divider settings
  output logic [12:0] main_count,
  output logic [4:0] swallow_count,
  output logic [13:0] ref_div_value,
  output logic [1:0] prescaler_val,
  output logic out_halve,
  output logic prescaler_src_sel,
  // Charge pump and phase detector
  output logic [2:0] pump_current,
  output logic pump_gain_select,
  output logic pump_enable,
  output logic phase_polarity,
  output logic [1:0] antibacklash_width,
  // Output stage and core
  output logic [1:0] output_power_level,
  output logic [1:0] core_power_level,
  output logic [2:0] muxout_sel,
  output logic rf_output_enable,
  output logic ref_buffer_enable,
  // Timing and status
  output logic counters_load,
  output logic ref_div_tick,
  output logic band_clk_tick,
  output logic digital_lock,
  output logic power_down,
  output synth_pkg::pd_state_t power_state,
  output logic [23:0] test_word
);
  import synth_pkg::*;

  // ==========================================================
  // Latches and internal state
  logic [23:0] mode_control_word;
  logic [23:0] feedback_divider_word;
  logic [23:0] reference_divider_word;
  logic [23:0] test_latch;
  logic [13:0] ref_cnt;
  logic [13:0] ref_limit;
  logic [2:0] band_cnt;
  logic [2:0] band_mask;
  logic ref_prev;
  logic ref_rise;
  logic power_down_arm;
  logic power_down_sync_sel;
  logic count_clear;
  logic mute_until_lock;
  logic lock_precision;
  logic factory_test_bit;
  logic [1:0] band_clk_div;
  latch_sel_t sel;

  serial_word_if link ();

  if (WORD_W != 24)
  begin : bad_width
    $error("synth_serial_latch_control: WORD_W must be 24");
  end

  // ==========================================================
  // Serial input register, alive in every power state
  serial_shifter shifter (
    .mclk(mclk),
    .reset(reset),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .load_strobe(load_strobe),
    .out(link.src)
  );

  assign sel = latch_sel_t'(link.word[`SEL_MSB:`SEL_LSB]); // [R1]

  // Each latch replaces all fields at once, only on its own select
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode_control_word <= `LATCH_RESET;
      feedback_divider_word <= `LATCH_RESET;
      reference_divider_word <= `LATCH_RESET;
      test_latch <= `LATCH_RESET;
    end
    else if (link.load)
    begin
      case (sel) // [R1] [R26] [R6]
        SEL_CONTROL: mode_control_word <= link.word;
        SEL_FEEDBACK: feedback_divider_word <= link.word;
        SEL_REFDIV: reference_divider_word <= link.word;
        SEL_TEST: test_latch <= link.word;
        default: test_latch <= test_latch;
      endcase
    end
  end

  // Shared gain flag: whichever word carried it last wins
  always_ff @(posedge mclk)
  begin
    if (reset)
      pump_gain_select <= 1'b0;
    else if (link.load && sel == SEL_CONTROL)
      pump_gain_select <= link.word[`CW_GAIN]; // [R8]
    else if (link.load && sel == SEL_FEEDBACK)
      pump_gain_select <= link.word[`FW_GAIN]; // [R8]
  end

  // ==========================================================
  // Field decode
  assign power_down_arm = mode_control_word[`CW_PD_ARM];
  assign power_down_sync_sel = mode_control_word[`CW_PD_SYNC];
  assign count_clear = mode_control_word[`CW_CLEAR];
  assign mute_until_lock = mode_control_word[`CW_MUTE];
  assign prescaler_val = mode_control_word[`CW_PRESC_MSB:`CW_PRESC_LSB];
  assign output_power_level = mode_control_word[`CW_PWR_MSB:`CW_PWR_LSB];
  assign core_power_level = mode_control_word[`CW_CORE_MSB:`CW_CORE_LSB];
  assign muxout_sel = mode_control_word[`CW_MUX_MSB:`CW_MUX_LSB];
  assign phase_polarity = mode_control_word[`CW_POLARITY]; // [R11]
  // Range limits are the host's to keep; values pass through unchanged
  assign swallow_count = feedback_divider_word[`FW_SWAL_MSB:`FW_SWAL_LSB]; // [R13]
  assign main_count = feedback_divider_word[`FW_MAIN_MSB:`FW_MAIN_LSB]; // [R14]
  assign out_halve = feedback_divider_word[`FW_HALVE]; // [R16]
  assign prescaler_src_sel = feedback_divider_word[`FW_SRC_SEL]; // [R16]
  assign ref_div_value = reference_divider_word[`RW_DIV_MSB:`RW_DIV_LSB]; // [R17]
  assign antibacklash_width = reference_divider_word[`RW_ABP_MSB:`RW_ABP_LSB]; // [R18]
  assign lock_precision = reference_divider_word[`RW_PRECISION];
  assign factory_test_bit = reference_divider_word[`RW_TEST];
  assign band_clk_div = reference_divider_word[`RW_BAND_MSB:`RW_BAND_LSB];
  // Test latch contents reach nothing unless the test bit is set
  assign test_word = factory_test_bit ? test_latch : `LATCH_RESET; // [R20]

  // Current field chosen by the shared gain flag
  assign pump_current = pump_gain_select ?
    mode_control_word[`CW_CUR_HI_MSB:`CW_CUR_HI_LSB] :
    mode_control_word[`CW_CUR_LO_MSB:`CW_CUR_LO_LSB]; // [R7]

  // ==========================================================
  // Power state: sync entry counts reference ticks after the strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
      power_state <= PD_RUN;
    else if (link.load && sel == SEL_CONTROL)
    begin
      if (!link.word[`CW_PD_ARM])
        power_state <= PD_RUN;
      else if (!link.word[`CW_PD_SYNC])
        power_state <= PD_DOWN; // [R2]
      else if (power_state != PD_DOWN)
        power_state <= PD_WAIT0; // [R3]
    end
    else if (ref_div_tick)
    begin
      case (power_state)
        PD_WAIT0: power_state <= PD_WAIT1; // [R3]
        PD_WAIT1: power_state <= PD_DOWN; // [R3]
        default: power_state <= power_state;
      endcase
    end
  end

  // Chip enable acts without any clock edge
  assign power_down = !chip_enable_pin || power_state == PD_DOWN; // [R4]

  // Side effects of any power-down
  assign counters_load = power_down || count_clear; // [R5] [R12]
  assign pump_enable = !power_down && !mode_control_word[`CW_TRISTATE]; // [R5] [R10]
  assign ref_buffer_enable = !power_down; // [R5]
  assign rf_output_enable = !power_down && (!mute_until_lock || digital_lock); // [R5] [R9]

  // ==========================================================
  // Reference divider: counts reference input rises
  assign ref_rise = ref_in && !ref_prev;
  assign ref_limit = (ref_div_value == 14'h0000) ? 14'h0000 : ref_div_value - 14'h0001;

  always_ff @(posedge mclk)
  begin
    if (reset)
      ref_prev <= 1'b0;
    else
      ref_prev <= ref_in;
  end

  // Held in load state while cleared or powered down
  always_ff @(posedge mclk)
  begin
    if (reset || counters_load)
    begin
      ref_cnt <= 14'h0000; // [R12] [R5]
      ref_div_tick <= 1'b0;
    end
    else
    begin
      ref_div_tick <= ref_rise && ref_cnt >= ref_limit;
      if (ref_rise)
        ref_cnt <= (ref_cnt >= ref_limit) ? 14'h0000 : ref_cnt + 14'h0001;
    end
  end

  // ==========================================================
  // Band select clock: divide reference ticks by 1, 2, 4 or 8
  always_comb
  begin
    case (band_clk_div) // [R24]
      2'b00: band_mask = 3'h0;
      2'b01: band_mask = 3'h1;
      2'b10: band_mask = 3'h3;
      2'b11: band_mask = 3'h7;
      default: band_mask = 3'h0;
    endcase
  end

  // Counter shares the dividers' load state
  always_ff @(posedge mclk)
  begin
    if (reset || counters_load)
    begin
      band_cnt <= 3'h0;
      band_clk_tick <= 1'b0;
    end
    else
    begin
      band_clk_tick <= ref_div_tick && ((band_cnt & band_mask) == band_mask); // [R21]
      if (ref_div_tick)
        band_cnt <= band_cnt + 3'h1;
    end
  end

  // ==========================================================
  // Lock detector, cleared by any power-down
  lock_detector #(
    .FAST_COUNT(`LOCK_CNT_FAST),
    .PRECISE_COUNT(`LOCK_CNT_PRECISE)
  ) lock_det (
    .mclk(mclk),
    .reset(reset),
    .clear(power_down), // [R5]
    .tick(ref_div_tick),
    .precise(lock_precision),
    .err_small(phase_err_small),
    .err_large(phase_err_large),
    .locked(digital_lock)
  );

  // ==========================================================
  // Checks
  logic [2:0] good_run;

  // Independent run counter so lock entry can be checked against it
  always_ff @(posedge mclk)
  begin
    if (reset || power_down)
      good_run <= 3'h0;
    else if (ref_div_tick)
      good_run <= phase_err_small ? ((good_run == 3'h7) ? good_run : good_run + 3'h1) : 3'h0;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  route_ctrl_a: assert property (link.load && sel == SEL_CONTROL
    |=> mode_control_word == $past(link.word)) // [R1]
    else $error("control word not latched");
  route_hold_a: assert property (link.load && sel == SEL_REFDIV
    |=> $stable(mode_control_word) && $stable(feedback_divider_word)) // [R26]
    else $error("other latch disturbed");
  async_pd_a: assert property (link.load && sel == SEL_CONTROL
    && link.word[`CW_PD_ARM] && !link.word[`CW_PD_SYNC] |=> power_down) // [R2]
    else $error("async power-down late");
  sync_pd_a: assert property (power_state == PD_WAIT0 && ref_div_tick && !link.load
    |=> power_state == PD_WAIT1) // [R3]
    else $error("sync power-down sequence broken");
  ce_low_a: assert property (!chip_enable_pin |-> power_down && !pump_enable
    && !rf_output_enable) // [R4]
    else $error("chip enable low not honoured");
  pd_effect_a: assert property (power_down |-> counters_load && !ref_buffer_enable
    ##1 (!digital_lock && ref_cnt == 14'h0000)) // [R5]
    else $error("power-down effects missing");
  pd_loads_a: assert property (power_down && link.load && sel == SEL_FEEDBACK
    |=> feedback_divider_word == $past(link.word)) // [R6]
    else $error("latch refused in power-down");
  gain_share_a: assert property (link.load && sel == SEL_FEEDBACK
    |=> pump_gain_select == $past(link.word[`FW_GAIN])) // [R8]
    else $error("gain flag not shared");
  pump_sel_a: assert property (pump_gain_select |-> pump_current
    == mode_control_word[`CW_CUR_HI_MSB:`CW_CUR_HI_LSB]) // [R7]
    else $error("wrong current field");
  mute_gate_a: assert property (mute_until_lock && !digital_lock |-> !rf_output_enable) // [R9]
    else $error("RF on before lock");
  tristate_a: assert property (mode_control_word[`CW_TRISTATE] |-> !pump_enable) // [R10]
    else $error("pump driven while tri-stated");
  clear_hold_a: assert property (count_clear |=> ref_cnt == 14'h0000 && !ref_div_tick) // [R12]
    else $error("dividers run during clear");
  lock_entry_a: assert property ($rose(digital_lock) |-> good_run
    == (lock_precision ? 3'(`LOCK_CNT_PRECISE) : 3'(`LOCK_CNT_FAST))) // [R19]
    else $error("lock entered after wrong run");
  lock_hold_a: assert property (digital_lock && ref_div_tick && !phase_err_large
    && !power_down ##1 !power_down |-> digital_lock) // [R25]
    else $error("lock dropped without large error");
  test_ignore_a: assert property (!factory_test_bit |-> test_word == `LATCH_RESET) // [R20]
    else $error("test latch leaked");

  async_pd_c: cover property (power_state == PD_RUN ##1 power_state == PD_DOWN);
  sync_pd_c: cover property (power_state == PD_WAIT1 ##1 power_state == PD_DOWN);
  lock_c: cover property ($rose(digital_lock));
  unlock_c: cover property ($fell(digital_lock) && !power_down);
endmodule : synth_serial_latch_control

// ==== test/serial_host.sv ====
// Host model: writes 24-bit words over the three-wire serial link.
// Assumes the block samples its pins on mclk; each serial clock phase lasts one mclk.
`timescale 1ns/1ns
module serial_host (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  // ==========================================================
  // Idle levels; the serial clock stands low between frames
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // ==========================================================
  // One write; callers pass words with spare bits zero, in power-up order
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) // Bit 23 goes first
    begin
      @(posedge mclk);
      ser_clk <= 1'b0;
      ser_data <= w[i];
      @(posedge mclk);
      ser_clk <= 1'b1;
    end
    // Strobe rise moves the word; data is flipped so nobody leans on a stale bit
    @(posedge mclk);
    ser_clk <= 1'b0;
    ser_data <= ~w[0];
    load_strobe <= 1'b1;
    @(posedge mclk);
    load_strobe <= 1'b0;
  endtask : send
endmodule : serial_host

// ==== test/synth_serial_latch_control_tb_top.sv ====
// Self-checking bench for the synthesizer control block.
// Assumes one 10 MHz clock; the reference input is a free square wave made here.
`timescale 1ns/1ns
module synth_serial_latch_control_tb_top;
  import synth_pkg::*;
  // ==========================================================
  // Words, spare bits all zero
  localparam logic [23:0] W_REF = 24'h02_000D; // Ratio 3, width code 2
  localparam logic [23:0] W_PREC = 24'h06_000D; // Same, five-cycle lock
  localparam logic [23:0] W_CTL = 24'h0A_8100; // Fields 5 and 2, positive sense
  localparam logic [23:0] W_FLD = 24'h8A_91AC; // Same, plus prescaler, power, mux, core codes
  localparam logic [23:0] W_CLR = 24'h0A_8310; // Plus pump float and count clear
  localparam logic [23:0] W_MUTE = 24'h0A_8900; // Plus mute until lock
  localparam logic [23:0] W_APD = 24'h1A_8100; // Armed, immediate
  localparam logic [23:0] W_SPD = 24'h3A_8100; // Armed, synchronous
  localparam logic [23:0] W_FB = 24'hFF_FF7E; // Max counts, halving, gain set
  localparam logic [23:0] W_FB3 = 24'h00_0302; // Main count 3, all else zero
  localparam logic [23:0] W_TST = 24'hAB_CDEF; // Test latch select
  // ==========================================================
  // Pins and observed outputs
  logic mclk, reset, ser_clk, ser_data, load_strobe, chip_enable_pin, ref_in;
  logic phase_err_small, phase_err_large, out_halve, prescaler_src_sel;
  logic pump_gain_select, pump_enable, phase_polarity, rf_output_enable, ref_buffer_enable;
  logic counters_load, ref_div_tick, band_clk_tick, digital_lock, power_down;
  logic [12:0] main_count;
  logic [4:0] swallow_count;
  logic [13:0] ref_div_value;
  logic [2:0] pump_current;
  logic [1:0] antibacklash_width;
  logic [1:0] prescaler_val, output_power_level, core_power_level;
  logic [2:0] muxout_sel;
  logic [23:0] test_word;
  pd_state_t power_state;
  int n_mismatch = 0;
  int compares = 0;
  synth_serial_latch_control i_dut (
    .mclk, .reset, .ser_clk, .ser_data, .load_strobe, .chip_enable_pin, .ref_in,
    .phase_err_small, .phase_err_large, .main_count, .swallow_count, .ref_div_value,
    .prescaler_val, .out_halve, .prescaler_src_sel, .pump_current, .pump_gain_select,
    .pump_enable, .phase_polarity, .antibacklash_width, .output_power_level,
    .core_power_level, .muxout_sel, .rf_output_enable, .ref_buffer_enable,
    .counters_load, .ref_div_tick, .band_clk_tick, .digital_lock, .power_down,
    .power_state, .test_word
  );
  serial_host i_host (.mclk, .ser_clk, .ser_data, .load_strobe);
  // ==========================================================
  // Clock and a reference input rising every four clocks
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always
  begin
    repeat (2) @(posedge mclk);
    ref_in <= ~ref_in;
  end
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Write a word, then wait the two edges the latch needs
  task automatic wr(input logic [23:0] w);
    i_host.send(w);
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr
  // Wait for n reference ticks, each followed by one edge for registered results
  task automatic ticks(input int n);
    int g;
    repeat (n)
    begin
      for (g = 0; g < 99 && ref_div_tick !== 1'b1; g++) @(posedge mclk) #1;
      // A tick that never comes is a failure, not a silent skip
      if (ref_div_tick !== 1'b1)
        n_mismatch++;
      @(posedge mclk) #1;
    end
  endtask : ticks
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // ==========================================================
  // Main sequence
  initial
  begin
    int nb;
    reset = 1'b1;
    chip_enable_pin = 1'b1;
    ref_in = 1'b0;
    phase_err_small = 1'b0;
    phase_err_large = 1'b0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk) #1;
    chk(power_state, PD_RUN);
    chk({power_down, pump_enable, rf_output_enable, ref_buffer_enable, counters_load}, 5'h0E);
    chk(phase_polarity, 1'b0);
    // Power-up order: reference, control, feedback
    wr(W_REF);
    chk(ref_div_value, 14'h0003);
    chk(antibacklash_width, 2'h2);
    wr(W_CTL);
    chk(pump_current, 3'h2);
    chk(phase_polarity, 1'b1);
    wr(W_FB);
    chk({out_halve, prescaler_src_sel, pump_gain_select, pump_current}, 6'h3D);
    chk(main_count, 13'h1FFF);
    chk(swallow_count, 5'h1F);
    chk(ref_div_value, 14'h0003);
    wr(W_FLD);
    chk({pump_gain_select, pump_current}, 4'h2);
    chk({prescaler_val, output_power_level, muxout_sel, core_power_level}, 9'h137);
    wr(W_CLR);
    chk({pump_enable, counters_load, power_down}, 3'h2);
    wr(W_CTL);
    chk({pump_enable, counters_load}, 2'h2);
    $display("test latches done");
    // Immediate power-down, writes still accepted while down
    wr(W_APD);
    chk(power_state, PD_DOWN);
    chk({power_down, pump_enable, rf_output_enable, ref_buffer_enable, counters_load}, 5'h11);
    wr(W_FB3);
    chk(main_count, 13'h0003);
    chk({swallow_count, out_halve}, 6'h00);
    wr(W_TST);
    chk(test_word, 24'h00_0000);
    chk(main_count, 13'h0003);
    wr(W_CTL);
    chk(power_down, 1'b0);
    @(posedge mclk);
    chip_enable_pin <= 1'b0;
    #1;
    chk({power_down, ref_buffer_enable}, 2'h2);
    @(posedge mclk);
    chip_enable_pin <= 1'b1;
    // Synchronous power-down lands on the second reference tick
    wr(W_SPD);
    chk(power_down, 1'b0);
    ticks(1);
    chk({power_state, power_down}, 3'h4);
    ticks(1);
    chk({power_state, power_down}, 3'h7);
    wr(W_CTL);
    $display("test power done");
    // Lock after three good cycles, five when precise; mute follows lock
    wr(W_MUTE);
    chk(rf_output_enable, 1'b0);
    @(posedge mclk);
    phase_err_small <= 1'b1;
    ticks(2);
    chk(digital_lock, 1'b0);
    ticks(1);
    chk({digital_lock, rf_output_enable}, 2'h3);
    @(posedge mclk);
    phase_err_small <= 1'b0;
    ticks(1);
    chk(digital_lock, 1'b1);
    @(posedge mclk);
    phase_err_large <= 1'b1;
    ticks(1);
    chk(digital_lock, 1'b0);
    @(posedge mclk);
    phase_err_large <= 1'b0;
    wr(W_PREC);
    @(posedge mclk);
    phase_err_small <= 1'b1;
    ticks(4);
    chk(digital_lock, 1'b0);
    ticks(1);
    chk(digital_lock, 1'b1);
    wr(W_APD);
    @(posedge mclk) #1;
    chk(digital_lock, 1'b0);
    phase_err_small <= 1'b0;
    wr(W_CTL);
    $display("test lock done");
    // Band clock: sixteen reference ticks give 16 >> code band ticks
    for (int k = 0; k < 4; k++)
    begin
      wr(W_REF | (24'(k) << 20));
      ticks(1);
      nb = 0;
      repeat (192)
      begin
        @(posedge mclk) #1;
        nb += band_clk_tick;
      end
      chk(nb, 16 >> k);
    end
    $display("test band done");
    results();
  end
  // ==========================================================
  // Watchdog; the run needs about 2000 clocks
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule : synth_serial_latch_control_tb_top
